// file: pkg/slst_pkg.sv
// Shared constants for the streaming burst user interface.
// Assumes both ends run on the same 20 MHz user clock.
package slst_pkg;
	localparam int LANE_W          = 64;
	localparam int TAG_W           = 8;
	localparam int FLAG_W          = 2;
	localparam int ERR_W           = 4;
	localparam int ERR_OVF         = 0;
	localparam int ERR_COR         = 1;
	localparam int ERR_UNC         = 2;
	localparam int ERR_GAP         = 3;
	localparam int CLK_PERIOD_NS   = 50;
	localparam int INIT_TIME_NS    = 3200;
	localparam int INIT_CYCLES     = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INIT_CNT_W      = 7;
	localparam int USER_RST_CYCLES = 4;
	localparam int FIFO_DEPTH      = 8;
	localparam int PFULL_MARGIN    = 3;
	localparam int BURST_GAP       = 2;
	localparam int GAP_CNT_W       = 8;
endpackage

// file: pkg/slst_if.sv
// Interface joining the core end and the user streaming end.
// Assumes both ends sit on one clock; no clocking block.
`timescale 1ns/1ps
interface slst_if #(
	parameter int LANES = 1
);
	import slst_pkg::*;
	logic [LANES*LANE_W-1:0] srcData;
	logic                    srcValid;
	logic                    srcFirst;
	logic                    srcLast;
	logic [TAG_W-1:0]        srcTag;
	logic                    srcReady;
	logic [ERR_W-1:0]        srcError;
	logic                    linkUp;
	logic                    userReset;
	logic [LANES*LANE_W-1:0] snkData;
	logic                    snkValid;
	logic                    snkFirst;
	logic                    snkLast;
	logic [TAG_W-1:0]        snkTag;

	modport core (
		input  srcData, srcValid, srcFirst, srcLast, srcTag,
		output srcReady, srcError, linkUp, userReset,
		output snkData, snkValid, snkFirst, snkLast, snkTag
	);
	modport user (
		output srcData, srcValid, srcFirst, srcLast, srcTag,
		input  srcReady, srcError, linkUp, userReset,
		input  snkData, snkValid, snkFirst, snkLast, snkTag
	);
endinterface // slst_if

// file: src/slst_core.sv
// Core end: source adaptation FIFO with optional ECC, link framing, sink framing.
// Assumes the link clock comes from outside and runs far slower than mclk.
// Operation
// (RULE1) Source marks first word for one cycle.
// (RULE2) Last marker pulses with the final word.
// (RULE3) Source keeps valid low between bursts.
// (RULE4) Sink keeps valid low between bursts.
// (RULE5) Invalid cycles inside a burst are skipped.
// (RULE6) Tag captured at start and end, carried; in continuous mode the code carries zero tags instead.
// (RULE7) Start tag counts only with first and valid.
// (RULE8) End tag holds empty count, zero single-lane.
// (RULE9) Start tag may carry logical channel.
// (RULE10) Sink shows start tag from received word.
// (RULE11) Sink shows end tag at its last cycle.
// (RULE12) Source data is 64 bits per lane.
// (RULE13) Ready low until link is up.
// (RULE14) Ready drops on reset, link loss, partial-full.
// (RULE15) User withholds valid while ready is low.
// (RULE16) Link up only after initialization finishes.
// (RULE17) Several PLL locks are ANDed outside.
// (RULE18) User reset clears the user domain.
// (RULE19) ECC FIFO reports corrected and uncorrectable upsets.
// (RULE20) ECC adds a pipeline cycle.
// (RULE21) Continuous mode marks first only once; the code marks first at every burst start in both modes.
// (RULE22) Four-bit error: overflow, corrected, uncorrectable, gap.
// (RULE23) Accepted words leave in order, none lost.
//
// Implementation choices: the placing of the registers.
`timescale 1ns/1ps
module slst_core
	import slst_pkg::*;
#(
	parameter int LANES     = 1,
	parameter int DEPTH     = FIFO_DEPTH,
	parameter bit ECC_EN    = 1'b1,
	parameter int GAP_MIN   = BURST_GAP
) (
	input  wire logic                                mclk,        // user clock
	input  wire logic                                rst_n,       // async reset
	slst_if.core                                     u,           // user-facing port
	input  wire logic                                contMode,    // continuous mode
	input  wire logic                                pllLocked,   // ANDed PLL locks
	input  wire logic                                linkClk,     // link word clock
	output logic [LANES*LANE_W+TAG_W+FLAG_W-1:0]     txLinkWord,  // outgoing word
	output logic                                     txLinkValid, // outgoing valid
	input  wire logic [LANES*LANE_W+TAG_W+FLAG_W-1:0] rxLinkWord, // incoming word
	input  wire logic                                rxLinkValid  // incoming valid
);
	// (RULE12) Data is 64 bits per lane.
	localparam int DW = LANES * LANE_W;
	localparam int LW = DW + TAG_W + FLAG_W;
	localparam int EW = 2 * (LW + 1);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [2:0]                  lclk;
		logic [1:0]                  pll;
		logic [LW:0]                 rxS1;
		logic [LW:0]                 rxS2;
		logic [INIT_CNT_W-1:0]       initCnt;
		logic                        linkUp;
		logic                        ready;
		logic [2:0]                  rstCnt;
		logic                        userRst;
		logic [DEPTH-1:0][EW-1:0]    mem;
		logic [AW-1:0]               wrPtr;
		logic [AW-1:0]               rdPtr;
		logic [AW:0]                 count;
		logic [EW-1:0]               raw;
		logic                        rawPend;
		logic [LW-1:0]               txWord;
		logic                        txValid;
		logic [ERR_W-1:0]            err;
		logic [GAP_CNT_W-1:0]        gapCnt;
		logic                        gapArm;
		logic [DW-1:0]               snkData;
		logic                        snkValid;
		logic                        snkFirst;
		logic                        snkLast;
		logic [TAG_W-1:0]            snkTag;
		logic                        snkInBurst;
	} slst_core_s;

	slst_core_s q;
	slst_core_s d;

	// Each entry holds two parity-guarded copies of the word.
	function automatic logic [EW-1:0] eccEncode(input logic [LW-1:0] w);
		eccEncode = {^w, w, ^w, w};
	endfunction

	logic            linkEdge;
	logic            push;
	logic            pop;
	logic [LW-1:0]   wordIn;
	logic [TAG_W-1:0] tagIn;
	logic [LW-1:0]   copyA;
	logic [LW-1:0]   copyB;
	logic            okA;
	logic            okB;
	logic [LW-1:0]   rxWord;

	always_comb begin
		d        = q;
		push     = 1'b0;
		pop      = 1'b0;
		linkEdge = q.lclk[1] & ~q.lclk[2];
		d.lclk   = {q.lclk[1], q.lclk[0], linkClk};
		d.pll    = {q.pll[0], pllLocked};
		d.rxS1   = {rxLinkValid, rxLinkWord};
		d.rxS2   = q.rxS1;
		d.err    = '0;

		// (RULE16) Link comes up after the init count.
		if (!q.pll[1]) begin
			d.initCnt = '0;
			d.linkUp  = 1'b0;
		end else if (q.initCnt == INIT_CNT_W'(INIT_CYCLES)) begin
			d.linkUp = 1'b1;
		end else begin
			d.initCnt = q.initCnt + 1'b1;
		end

		// (RULE18) User reset held after release.
		if (q.rstCnt != 3'(USER_RST_CYCLES)) begin
			d.rstCnt = q.rstCnt + 1'b1;
		end
		d.userRst = (d.rstCnt != 3'(USER_RST_CYCLES));

		// (RULE7) Start tag only with first and valid.
		tagIn = '0;
		if (!contMode && (u.srcFirst || u.srcLast)) begin
			tagIn = u.srcTag;
		end
		// (RULE6) Tag rides inside the link word.
		wordIn = {u.srcFirst, u.srcLast, tagIn, u.srcData};

		// (RULE5) Only valid cycles are stored.
		if (u.srcValid && !q.userRst) begin
			if (q.count == (AW+1)'(DEPTH)) begin
				// (RULE22) Overflow flag.
				d.err[ERR_OVF] = 1'b1;
			end else begin
				// (RULE23) Words enter in order.
				d.mem[q.wrPtr] = eccEncode(wordIn);
				d.wrPtr        = q.wrPtr + 1'b1;
				push           = 1'b1;
			end
		end

		// (RULE20) Read, then check one cycle later.
		d.rawPend = 1'b0;
		if (linkEdge) begin
			if (q.count != '0) begin
				d.raw     = q.mem[q.rdPtr];
				d.rdPtr   = q.rdPtr + 1'b1;
				d.rawPend = 1'b1;
				pop       = 1'b1;
			end else begin
				d.txValid = 1'b0;
			end
		end

		copyA = q.raw[LW-1:0];
		copyB = q.raw[EW-2:LW+1];
		okA   = (^copyA) == q.raw[LW];
		okB   = (^copyB) == q.raw[EW-1];
		if (q.rawPend) begin
			d.txValid = 1'b1;
			d.txWord  = copyA;
			// (RULE19) Corrected versus uncorrectable report.
			if (ECC_EN) begin
				if (okA && okB && copyA != copyB) begin
					d.err[ERR_UNC] = 1'b1;
				end else if (!okA && okB) begin
					d.txWord       = copyB;
					d.err[ERR_COR] = 1'b1;
				end else if (okA && !okB) begin
					d.err[ERR_COR] = 1'b1;
				end else if (!okA && !okB) begin
					d.err[ERR_UNC] = 1'b1;
				end
			end
		end

		d.count = (AW+1)'(q.count + (AW+1)'(push) - (AW+1)'(pop));

		// (RULE13) (RULE14) Ready needs link up and room.
		d.ready = d.linkUp && !d.userRst && (d.count < (AW+1)'(DEPTH - PFULL_MARGIN));

		// (RULE22) Gap between last and next first.
		if (q.gapArm && q.gapCnt != '1) begin
			d.gapCnt = q.gapCnt + 1'b1;
		end
		if (u.srcValid && !q.userRst) begin
			if (u.srcFirst) begin
				d.gapArm = 1'b0;
				if (!contMode && q.gapArm && q.gapCnt < GAP_CNT_W'(GAP_MIN)) begin
					d.err[ERR_GAP] = 1'b1;
				end
			end
			if (u.srcLast) begin
				d.gapArm = 1'b1;
				d.gapCnt = '0;
			end
		end

		// (RULE2) (RULE4) Sink framing, one pulse per word.
		d.snkValid = 1'b0;
		d.snkFirst = 1'b0;
		d.snkLast  = 1'b0;
		rxWord     = q.rxS2[LW-1:0];
		if (linkEdge && q.rxS2[LW] && (q.snkInBurst || rxWord[LW-1])) begin
			d.snkValid = 1'b1;
			d.snkData  = rxWord[DW-1:0];
			// (RULE21) First passes as received, in both modes.
			d.snkFirst = rxWord[LW-1];
			d.snkLast  = rxWord[LW-2];
			// (RULE10) (RULE11) Tag extracted from the word.
			d.snkTag     = rxWord[DW+TAG_W-1:DW];
			d.snkInBurst = !rxWord[LW-2];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.userRst <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign u.srcReady  = q.ready;
	assign u.srcError  = q.err;
	assign u.linkUp    = q.linkUp;
	assign u.userReset = q.userRst;
	assign u.snkData   = q.snkData;
	assign u.snkValid  = q.snkValid;
	assign u.snkFirst  = q.snkFirst;
	assign u.snkLast   = q.snkLast;
	assign u.snkTag    = q.snkTag;
	assign txLinkWord  = q.txWord;
	assign txLinkValid = q.txValid;
endmodule // slst_core

// file: src/slst_user.sv
// User streaming end: frames a word stream into bursts and collects sink words.
// Assumes the core end shares mclk and drives userReset.
`timescale 1ns/1ps
module slst_user
	import slst_pkg::*;
#(
	parameter int LANES = 1
) (
	input  wire logic                    mclk,      // user clock
	input  wire logic                    rst_n,     // async reset
	slst_if.user                         u,         // core-facing port
	input  wire logic [LANES*LANE_W-1:0] wrData,    // word to send
	input  wire logic                    wrValid,   // word offered
	input  wire logic                    wrLast,    // final word of burst
	input  wire logic [TAG_W-1:0]        wrChannel, // logical channel
	input  wire logic [TAG_W-1:0]        wrEmpty,   // empty words at end
	output logic                         wrReady,   // word taken if valid
	output logic [LANES*LANE_W-1:0]      rdData,    // received word
	output logic                         rdValid,   // received word pulse
	output logic                         rdFirst,   // burst start pulse
	output logic                         rdLast,    // burst end pulse
	output logic [TAG_W-1:0]             rdTag,     // received tag
	output logic                         linkReady, // link is up
	output logic [ERR_W-1:0]             errSeen    // sticky core errors
);
	localparam int DW = LANES * LANE_W;

	typedef struct packed {
		logic [DW-1:0]    srcData;
		logic             srcValid;
		logic             srcFirst;
		logic             srcLast;
		logic [TAG_W-1:0] srcTag;
		logic             inBurst;
		logic             wrReady;
		logic [DW-1:0]    rdData;
		logic             rdValid;
		logic             rdFirst;
		logic             rdLast;
		logic [TAG_W-1:0] rdTag;
		logic             linkReady;
		logic [ERR_W-1:0] errSeen;
	} slst_user_s;

	slst_user_s q;
	slst_user_s d;
	logic       take;

	always_comb begin
		d    = q;
		// (RULE15) Words taken only after ready was high.
		take = wrValid && q.wrReady && !u.userReset;
		d.wrReady = u.srcReady && !u.userReset;

		// (RULE1) (RULE3) Valid only on burst words.
		d.srcValid = take;
		d.srcFirst = take && !q.inBurst;
		// (RULE2) Last marks the final word only.
		d.srcLast  = take && wrLast;
		d.srcData  = wrData;
		d.srcTag   = '0;
		if (take && !q.inBurst) begin
			// (RULE9) Channel number in the start tag.
			d.srcTag = wrChannel;
		end else if (take && wrLast) begin
			// (RULE8) Empty count, zero with one lane.
			d.srcTag = (LANES == 1) ? '0 : wrEmpty;
		end
		if (take) begin
			d.inBurst = !wrLast;
		end

		// (RULE5) Skip sink cycles without valid.
		d.rdValid = u.snkValid;
		d.rdFirst = u.snkValid && u.snkFirst;
		d.rdLast  = u.snkValid && u.snkLast;
		if (u.snkValid) begin
			d.rdData = u.snkData;
			d.rdTag  = u.snkTag;
		end
		d.linkReady = u.linkUp;
		d.errSeen   = q.errSeen | u.srcError;

		// (RULE18) Core-driven reset clears this end.
		if (u.userReset) begin
			d = '0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign u.srcData  = q.srcData;
	assign u.srcValid = q.srcValid;
	assign u.srcFirst = q.srcFirst;
	assign u.srcLast  = q.srcLast;
	assign u.srcTag   = q.srcTag;
	assign wrReady    = q.wrReady;
	assign rdData     = q.rdData;
	assign rdValid    = q.rdValid;
	assign rdFirst    = q.rdFirst;
	assign rdLast     = q.rdLast;
	assign rdTag      = q.rdTag;
	assign linkReady  = q.linkReady;
	assign errSeen    = q.errSeen;
endmodule // slst_user

// file: testbench/slst_checker.sv
// Checker for the framing and readiness seen between the two ends.
// Assumes one clock and the bench wiring it beside the interface.
`timescale 1ns/1ps
module slst_checker
	import slst_pkg::*;
#(
	parameter int LANES = 1
) (
	input wire logic             mclk,      // user clock
	input wire logic             rst_n,     // async reset
	input wire logic             srcValid,  // source word
	input wire logic             srcFirst,  // source first
	input wire logic             srcLast,   // source last
	input wire logic [TAG_W-1:0] srcTag,    // source tag
	input wire logic             srcReady,  // source ready
	input wire logic             linkUp,    // link up
	input wire logic             userReset, // user reset
	input wire logic             snkValid,  // sink word
	input wire logic             snkFirst,  // sink first
	input wire logic             snkLast    // sink last
);
	logic srcIn_q;
	logic snkIn_q;

	// Tracks whether a burst is open on each side.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			srcIn_q <= 1'b0;
			snkIn_q <= 1'b0;
		end else begin
			if (srcValid) begin
				srcIn_q <= !srcLast;
			end
			if (snkValid) begin
				snkIn_q <= !snkLast;
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_srcEnd;
		srcValid && srcLast && !srcFirst;
	endsequence
	sequence s_snkEnd;
		snkValid && snkLast;
	endsequence

	property p_readyLink; srcReady |-> linkUp; endproperty
	property p_userRstQuiet; userReset |-> !srcReady && !srcValid && !snkValid; endproperty
	property p_srcMarks; (srcFirst || srcLast) |-> srcValid; endproperty
	property p_srcOutside; srcValid |-> srcFirst || srcIn_q; endproperty
	property p_srcEndTag; s_srcEnd |-> (LANES > 1) || (srcTag == 8'h00); endproperty
	property p_readyPressure; srcValid |-> $past(srcReady, 2); endproperty
	property p_snkPulse; s_snkEnd |=> !snkLast; endproperty
	property p_snkMarks; (snkFirst || snkLast) |-> snkValid; endproperty
	property p_snkOutside; snkValid |-> snkFirst || snkIn_q; endproperty

	a_readyLink: assert property (p_readyLink)
		else $error("ready high without link");
	a_userRstQuiet: assert property (p_userRstQuiet)
		else $error("activity during user reset");
	a_srcMarks: assert property (p_srcMarks)
		else $error("source marker without valid");
	a_srcOutside: assert property (p_srcOutside)
		else $error("source valid outside a burst");
	a_srcEndTag: assert property (p_srcEndTag)
		else $error("single lane end tag not zero");
	a_readyPressure: assert property (p_readyPressure)
		else $error("source word while ready low");
	a_snkPulse: assert property (p_snkPulse)
		else $error("sink last longer than a cycle");
	a_snkMarks: assert property (p_snkMarks)
		else $error("sink marker without valid");
	a_snkOutside: assert property (p_snkOutside)
		else $error("sink valid outside a burst");
endmodule // slst_checker

// file: testbench/tb_top.sv
// Bench joining the core and user ends, with the link looped back.
// Assumes the link words are relaunched on the falling link clock.
`timescale 1ns/1ps
module tb_top
	import slst_pkg::*;
;
	localparam int WW = LANE_W + TAG_W + FLAG_W;
	logic             mclk;
	logic             rst_n;
	logic             pllLocked;
	logic             linkClk;
	logic             linkEn;
	logic             contMode;
	logic [WW-1:0]    txWord;
	logic             txValid;
	logic [WW-1:0]    rxWord;
	logic             rxValid;
	logic [63:0]      wrData;
	logic             wrValid;
	logic             wrLast;
	logic [7:0]       wrChannel;
	logic [7:0]       wrEmpty;
	logic             wrReady;
	logic [63:0]      rdData;
	logic             rdValid;
	logic             rdFirst;
	logic             rdLast;
	logic [7:0]       rdTag;
	logic             linkReady;
	logic [3:0]       errSeen;
	logic             sawLow;
	logic [WW-1:0]    got[$];
	logic [WW-1:0]    exp[$];
	int               fails;
	int               n_tests;
	int               k;

	slst_if #(.LANES(1)) u_slst_if ();
	slst_core #(.LANES(1)) u_slst_core (.mclk(mclk), .rst_n(rst_n), .u(u_slst_if),
		.contMode(contMode), .pllLocked(pllLocked), .linkClk(linkClk), .txLinkWord(txWord),
		.txLinkValid(txValid), .rxLinkWord(rxWord), .rxLinkValid(rxValid));
	slst_user #(.LANES(1)) u_slst_user (.mclk(mclk), .rst_n(rst_n), .u(u_slst_if),
		.wrData(wrData), .wrValid(wrValid), .wrLast(wrLast), .wrChannel(wrChannel),
		.wrEmpty(wrEmpty), .wrReady(wrReady), .rdData(rdData), .rdValid(rdValid),
		.rdFirst(rdFirst), .rdLast(rdLast), .rdTag(rdTag), .linkReady(linkReady),
		.errSeen(errSeen));
	slst_checker #(.LANES(1)) u_slst_checker (.mclk(mclk), .rst_n(rst_n),
		.srcValid(u_slst_if.srcValid), .srcFirst(u_slst_if.srcFirst),
		.srcLast(u_slst_if.srcLast), .srcTag(u_slst_if.srcTag),
		.srcReady(u_slst_if.srcReady), .linkUp(u_slst_if.linkUp),
		.userReset(u_slst_if.userReset), .snkValid(u_slst_if.snkValid),
		.snkFirst(u_slst_if.snkFirst), .snkLast(u_slst_if.snkLast));

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// The link clock stops low while disabled, to stall the link.
	initial begin
		linkClk = 1'b0;
		#7;
		forever #200 linkClk = linkEn ? ~linkClk : 1'b0;
	end

	always @(negedge linkClk) begin
		rxWord <= txWord;
		rxValid <= txValid;
	end

	always @(posedge mclk) begin
		if (rdValid) begin
			got.push_back({rdFirst, rdLast, rdTag, rdData});
		end
		if (linkReady && !u_slst_if.srcReady) begin
			sawLow <= 1'b1;
		end
	end

	task automatic check(input string name, input logic [WW-1:0] seen, input logic [WW-1:0] e);
		n_tests++;
		if (seen !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", name, e, seen);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic send_burst(input int n, input logic [7:0] ch, input logic [63:0] d0,
		input int gap);
		int t;
		for (int i = 0; i < n; i++) begin
			wrData <= d0 + 64'(i);
			wrValid <= 1'b1;
			wrLast <= (i == n - 1);
			wrChannel <= ch;
			wrEmpty <= 8'h00;
			exp.push_back({i == 0, i == n - 1, (i == 0 && !contMode) ? ch : 8'h00, d0 + 64'(i)});
			t = 0;
			do begin
				@(posedge mclk);
				t++;
			end while (!wrReady && t < 2000);
			if (t >= 2000) begin
				fails++;
				finish_test();
			end
		end
		wrValid <= 1'b0;
		wrLast <= 1'b0;
		repeat (gap) @(posedge mclk);
	endtask

	initial begin
		{rst_n, pllLocked, wrValid, wrLast, sawLow, rxValid, contMode} = '0;
		{wrData, wrChannel, wrEmpty, rxWord} = '0;
		linkEn = 1'b1;
		repeat (12) @(posedge mclk);
		check("srcReady", u_slst_if.srcReady, 0);
		check("userReset", u_slst_if.userReset, 1);
		rst_n <= 1'b1;
		repeat (100) @(posedge mclk);
		check("readyNoPll", {linkReady, u_slst_if.srcReady}, 0);
		// One line stands for ANDed locks.
		pllLocked <= 1'b1;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (!linkReady && k < 300);
		check("initTime", k >= INIT_CYCLES && k < 300, 1);
		$display("test reset done");
		foreach (exp[i]) ;
		for (int b = 1; b <= 4; b++) begin
			send_burst(b + b / 4, 8'(b * 8'h55), 64'h1000 * b, BURST_GAP + 1);
		end
		$display("test bursts done");
		linkEn = 1'b0;
		fork
			send_burst(12, 8'h3C, 64'hA000, BURST_GAP + 1);
			begin
				repeat (150) @(posedge mclk);
				check("readyDrop", sawLow, 1);
				check("readyStall", u_slst_if.srcReady, 0);
				linkEn = 1'b1;
			end
		join
		contMode <= 1'b1;
		@(posedge mclk);
		send_burst(3, 8'h77, 64'hC000, BURST_GAP + 1);
		contMode <= 1'b0;
		$display("test continuous done");
		k = 0;
		while (got.size() < exp.size() && k < 3000) begin
			@(posedge mclk);
			k++;
		end
		check("count", got.size(), exp.size());
		foreach (exp[i]) begin
			check("word", (i < got.size()) ? got[i] : '0, exp[i]);
		end
		check("errSeen", errSeen, 0);
		$display("test stall done");
		send_burst(1, 8'h11, 64'hE000, 1);
		send_burst(1, 8'h22, 64'hE100, BURST_GAP + 1);
		check("errGap", errSeen, 1 << ERR_GAP);
		$display("test gap done");
		finish_test();
	end
endmodule // tb_top
